// [inc/cpp_pkg.sv]
// package for the charger power path control block
`default_nettype none
package cpp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] EXTERNAL_CURRENT_CLAMP_PIN_OFS  = 8'h04;
  localparam logic [7:0] BOOST_OFS = 8'h08;
  localparam logic [7:0] CHG_OFS   = 8'h0c;
  localparam logic [7:0] STAT_OFS  = 8'h10;
  // control register bit positions
  localparam int OPT_EN_B   = 0;
  localparam int OPT_RUN_B  = 1;
  localparam int CLAMP_EN_B = 2;
  localparam int BST_CFG_B  = 3;
  localparam int BST_FRQ_B  = 4;
  localparam int CHG_CFG_B  = 5;
  localparam int BSW_DIS_B  = 6;
  localparam int RCH_SEL_B  = 7;
  localparam int IND_DIS_B  = 8;
  // reset values
  localparam logic [8:0] CTRL_RST  = 9'h025;
  localparam logic [5:0] HILIM_RST = 6'h08;
  localparam logic [2:0] BLIM_RST  = 3'h3;
  localparam logic [3:0] BVOLT_RST = 4'h7;  // 5 V
  localparam logic [5:0] VREG_RST  = 6'h17; // 4.208 V
  localparam logic [6:0] FAST_CHARGE_CURRENT_FIELD_RST  = 7'h20; // 2.048 A
  localparam logic [3:0] IPRE_RST  = 4'h1;  // 128 mA
  localparam logic [3:0] ITRM_RST  = 4'h3;  // 256 mA
  localparam logic [1:0] TMR_RST   = 2'h2;  // 12 hour
  localparam logic [2:0] SMIN_RST  = 3'h5;  // 3.5 V
  // fixed codes
  localparam logic [2:0] SRC_BOOST = 3'h7;
  localparam logic [1:0] PH_DIS    = 2'h0;
  localparam logic [1:0] PH_PRE    = 2'h1;
  localparam logic [1:0] PH_FAST   = 2'h2;
  localparam logic [1:0] PH_DONE   = 2'h3;
  localparam logic [1:0] CUR_SHORT = 2'h0;
  localparam logic [1:0] CUR_PRE   = 2'h1;
  localparam logic [1:0] CUR_FAST  = 2'h2;
  // timing
  localparam int CLK_MHZ      = 250;
  localparam int BOOST_DLY_MS = 30;
  localparam int BOOST_DLY_CYC = BOOST_DLY_MS * 1000 * CLK_MHZ;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int BLINK_MS     = 500;
  localparam int BLINK_CYC    = BLINK_MS * 1000 * CLK_MHZ;

  // analog comparator and detector results arriving from outside
  typedef struct packed {
    logic       conv_running;
    logic       src_dcp_found;   // dcp or high-voltage adapter detected
    logic [2:0] src_type;
    logic       opt_done;
    logic [5:0] opt_result;
    logic [5:0] ext_clamp;       // external_current_clamp_pin code
    logic       boost_request_pin;
    logic       bat_above_low;
    logic       vbus_below_sleep;
    logic       boost_temp_ok;
    logic       bat_above_boost;
    logic       sys_at_min;
    logic       iin_over;
    logic       vin_under;
    logic       sys_below_bat;
    logic       bat_depleted;
    logic       charge_en_n;
    logic       ts_fault;
    logic       timer_fault;
    logic       bat_above_2v;
    logic       bat_above_3v;
    logic       bat_above_rechg;
    logic       ibat_below_term;
    logic       thermal_reg;
  } cpp_sense_t;

  // settings handed to the analog side
  typedef struct packed {
    logic [5:0]  eff_input_limit;
    logic [11:0] boost_limit_ma;
    logic [3:0]  boost_voltage;
    logic        boost_frequency_select_fast;
    logic [2:0]  min_sys_voltage;
    logic [5:0]  charge_voltage;
    logic [6:0]  fast_current;
    logic [3:0]  pre_current;
    logic [3:0]  term_current;
    logic [1:0]  timer_sel;
    logic [1:0]  current_sel;
    logic        recharge_sel;
  } cpp_cfg_t;
endpackage : cpp_pkg
`default_nettype wire

// [hw/cpp_ctrl.sv]
// charger power path control with wishbone register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: optimizer enabled at reset, host may clear
// R2: optimizer runs after dcp detect or force
// R3: limit from optimizer result else host register
// R4: limit clamped by pin unless clamp disabled
// R5: boost limit code 000 gives 500 mA
// R6: boost starts only when six conditions hold
// R7: frequency bit writes ignored while boost configured
// R8: source status reads 111 during boost
// R9: boost stops when battery below boost threshold
// R10: minimum system field resets to 3.5 V
// R11: system regulation flag follows minimum regulation
// R12: overload reduces charge current until clear
// R13: voltage and current regulation flags shown
// R14: supplement on sys below bat, off depleted
// R15: autonomous charge cycles with config and pin
// R16: charging parameter reset values fixed
// R17: new cycle needs all start conditions
// R18: terminate on low current, high voltage, unregulated
// R19: recharge below threshold or enable toggle
// R20: indicator low charging, high done, blink fault
// R21: phase codes and interrupt on completion
// R22: start phase selected from battery voltage
// R23: regulation suppresses termination, halves timer rate
// R24: interrupt single pulse after status update
module cpp_ctrl
  import cpp_pkg::*;
#(
  parameter int BOOST_DLY = BOOST_DLY_CYC,
  parameter int TICK_DIV  = TICK_CYC,
  parameter int BLINK_DIV = BLINK_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // analog side
  input  wire cpp_sense_t  sense_i,
  output cpp_cfg_t         cfg_o,
  output logic             opt_run_o,
  output logic             boost_active_o,
  output logic             charge_reduce_o,
  output logic             bat_switch_on_o,
  output logic             charging_o,
  output logic             safety_tick_o,
  // host side pins
  output logic             int_o,
  output logic             ind_o,
  output logic             ind_oe_o
);

  // two-flop synchroniser for every analog sense input
  cpp_sense_t sync1;
  cpp_sense_t s;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      s     <= '0;
    end else begin
      sync1 <= sense_i;
      s     <= sync1;
    end
  end

  // boost current code to milliamps
  function automatic logic [11:0] boost_ma(input logic [2:0] code);
    case (code)
      3'h0:    boost_ma = 12'd500; // R5
      3'h1:    boost_ma = 12'd750;
      3'h2:    boost_ma = 12'd1200;
      3'h3:    boost_ma = 12'd1400;
      3'h4:    boost_ma = 12'd1650;
      3'h5:    boost_ma = 12'd1875;
      3'h6:    boost_ma = 12'd2150;
      default: boost_ma = 12'd2400;
    endcase
  endfunction : boost_ma

  // registers
  logic [8:0] ctrl;
  logic [5:0] host_input_current_limit;
  logic [5:0] optimized_input_limit;
  logic [2:0] boost_current_limit_field;
  logic [3:0] boost_voltage_field;
  logic [5:0] vreg;
  logic [6:0] fast_charge_current_field;
  logic [3:0] ipre;
  logic [3:0] iterm;
  logic [1:0] tmr;
  logic [2:0] minimum_system_voltage_field;
  logic [1:0] charge_phase_field;
  logic [2:0] input_source_status;
  logic       wr;
  logic       rd;
  logic       run_now;
  logic       dcp_q;

  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd = cyc_i && stb_i && !ack_o;

  // bus acknowledge one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_o <= 1'b0;
    else       ack_o <= cyc_i && stb_i && !ack_o;
  end

  // control register writes; force bit clears when run issued
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST; // R1
    end else begin
      if (run_now) ctrl[OPT_RUN_B] <= 1'b0;
      if (wr && adr_i == CTRL_OFS) begin
        ctrl[OPT_EN_B]   <= dat_i[OPT_EN_B]; // R1
        ctrl[CLAMP_EN_B] <= dat_i[CLAMP_EN_B];
        ctrl[BST_CFG_B]  <= dat_i[BST_CFG_B];
        ctrl[CHG_CFG_B]  <= dat_i[CHG_CFG_B];
        ctrl[BSW_DIS_B]  <= dat_i[BSW_DIS_B];
        ctrl[RCH_SEL_B]  <= dat_i[RCH_SEL_B];
        if (sel_i[1]) ctrl[IND_DIS_B] <= dat_i[IND_DIS_B];
        if (!ctrl[BST_CFG_B]) ctrl[BST_FRQ_B] <= dat_i[BST_FRQ_B]; // R7
        if (dat_i[OPT_RUN_B]) ctrl[OPT_RUN_B] <= 1'b1; // set wins
      end
    end
  end

  // parameter registers, all written with byte lane 0 as qualifier
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_input_current_limit     <= HILIM_RST;
      boost_current_limit_field    <= BLIM_RST;
      boost_voltage_field          <= BVOLT_RST; // R8
      vreg                         <= VREG_RST;  // R16
      fast_charge_current_field    <= FAST_CHARGE_CURRENT_FIELD_RST;  // R16
      ipre                         <= IPRE_RST;  // R16
      iterm                        <= ITRM_RST;  // R16
      tmr                          <= TMR_RST;   // R16
      minimum_system_voltage_field <= SMIN_RST;  // R10
    end else if (wr) begin
      case (adr_i)
        EXTERNAL_CURRENT_CLAMP_PIN_OFS: host_input_current_limit <= dat_i[5:0];
        BOOST_OFS: begin
          boost_current_limit_field <= dat_i[2:0];
          boost_voltage_field       <= dat_i[7:4];
        end
        CHG_OFS: begin
          fast_charge_current_field    <= dat_i[6:0]; // R15
          ipre                         <= dat_i[11:8];
          iterm                        <= dat_i[15:12];
          vreg                         <= dat_i[21:16];
          tmr                          <= dat_i[23:22];
          minimum_system_voltage_field <= dat_i[26:24];
        end
        default: ;
      endcase
    end
  end

  // input limit optimizer start and result capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dcp_q                 <= 1'b0;
      opt_run_o             <= 1'b0;
      optimized_input_limit <= HILIM_RST;
    end else begin
      dcp_q     <= s.src_dcp_found;
      opt_run_o <= run_now; // R2
      if (s.opt_done) optimized_input_limit <= s.opt_result;
    end
  end
  assign run_now = ctrl[OPT_EN_B] && !opt_run_o &&
                   ((s.src_dcp_found && !dcp_q) || ctrl[OPT_RUN_B]); // R2

  // effective input limit selection and pin clamp
  logic [5:0] base_lim;
  logic [5:0] next_eff;
  always_comb begin
    base_lim = ctrl[OPT_EN_B] ? optimized_input_limit
                              : host_input_current_limit; // R3
    next_eff = base_lim;
    if (ctrl[CLAMP_EN_B] && s.ext_clamp < base_lim)
      next_eff = s.ext_clamp; // R4
  end

  // boost enable delay, start and hold
  logic        boost_en;
  logic [31:0] bdly;
  logic        bdly_done;
  logic        boost_ok;
  assign boost_en  = s.boost_request_pin && ctrl[BST_CFG_B];
  assign bdly_done = (bdly >= 32'(BOOST_DLY));
  assign boost_ok  = boost_en && bdly_done && s.boost_temp_ok;
  always_ff @(posedge clk_i) begin
    if (rst_i)          bdly <= '0;
    else if (!boost_en) bdly <= '0;
    else if (!bdly_done) bdly <= bdly + 32'd1; // R6
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_active_o <= 1'b0;
    end else if (!boost_active_o) begin
      boost_active_o <= boost_ok && s.bat_above_low &&
                        s.vbus_below_sleep; // R6
    end else begin
      boost_active_o <= boost_ok && s.bat_above_boost; // R9
    end
  end

  // status flags and settings outputs
  logic sys_flag;
  logic vdpm_flag;
  logic idpm_flag;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_source_status <= '0;
      sys_flag            <= 1'b0;
      vdpm_flag           <= 1'b0;
      idpm_flag           <= 1'b0;
      charge_reduce_o     <= 1'b0;
    end else begin
      input_source_status <= boost_active_o ? SRC_BOOST : s.src_type; // R8
      sys_flag            <= s.sys_at_min; // R11
      vdpm_flag           <= s.vin_under;  // R13
      idpm_flag           <= s.iin_over;   // R13
      charge_reduce_o     <= s.vin_under || s.iin_over; // R12
    end
  end

  // supplement mode battery switch
  logic supp;
  always_ff @(posedge clk_i) begin
    if (rst_i)                supp <= 1'b0;
    else if (s.bat_depleted)  supp <= 1'b0; // R14
    else if (s.sys_below_bat) supp <= 1'b1; // R14
  end

  // charge cycle state machine
  typedef enum logic [4:0] {
    ST_DIS   = 5'b00001,
    ST_PRE   = 5'b00010,
    ST_FAST  = 5'b00100,
    ST_DONE  = 5'b01000,
    ST_FAULT = 5'b10000
  } cpp_chg_t;
  cpp_chg_t st;
  cpp_chg_t next_st;
  logic     en_ok;
  logic     start_ok;
  logic     regul;
  logic     term_ok;
  logic     fault;
  assign regul    = s.vin_under || s.iin_over || s.thermal_reg;
  assign fault    = s.ts_fault || s.timer_fault;
  assign en_ok    = ctrl[CHG_CFG_B] && !s.charge_en_n; // R15
  assign start_ok = s.conv_running && en_ok &&
                    fast_charge_current_field != 7'h00 && !fault &&
                    !ctrl[BSW_DIS_B]; // R17
  assign term_ok  = s.ibat_below_term && s.bat_above_rechg &&
                    !regul; // R18 R23
  always_comb begin
    next_st = st;
    case (st)
      ST_DIS: begin
        if (start_ok) next_st = s.bat_above_3v ? ST_FAST : ST_PRE; // R22
      end
      ST_PRE, ST_FAST: begin
        if (!en_ok || ctrl[BSW_DIS_B]) next_st = ST_DIS;
        else if (fault)                 next_st = ST_FAULT;
        else if (st == ST_FAST && term_ok) next_st = ST_DONE; // R18
        else if (st == ST_PRE && s.bat_above_3v) next_st = ST_FAST;
      end
      ST_DONE: begin
        if (!en_ok) next_st = ST_DIS; // R19
        else if (!s.bat_above_rechg && start_ok) begin
          next_st = s.bat_above_3v ? ST_FAST : ST_PRE; // R19
        end
      end
      ST_FAULT: begin
        if (!en_ok || !fault) next_st = ST_DIS;
      end
      default: next_st = ST_DIS;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) st <= ST_DIS;
    else       st <= next_st;
  end

  // phase field, charging and battery switch outputs, completion interrupt
  logic done_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_phase_field <= PH_DIS;
      done_q             <= 1'b0;
      int_o              <= 1'b0;
      charging_o         <= 1'b0;
      bat_switch_on_o    <= 1'b0;
    end else begin
      case (st)
        ST_PRE:  charge_phase_field <= PH_PRE;  // R21
        ST_FAST: charge_phase_field <= PH_FAST; // R21
        ST_DONE: charge_phase_field <= PH_DONE; // R21
        default: charge_phase_field <= PH_DIS;  // R21
      endcase
      done_q          <= (st == ST_DONE);
      int_o           <= (st == ST_DONE) && !done_q; // R21 R24
      charging_o      <= (st == ST_PRE) || (st == ST_FAST);
      bat_switch_on_o <= !ctrl[BSW_DIS_B] &&
                         ((st == ST_PRE) || (st == ST_FAST) || supp); // R14
    end
  end

  // safety timer tick, half rate while regulating
  logic [31:0] tick_cnt;
  logic        half;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt      <= '0;
      half          <= 1'b0;
      safety_tick_o <= 1'b0;
    end else begin
      safety_tick_o <= 1'b0;
      if (tick_cnt >= 32'(TICK_DIV - 1)) begin
        tick_cnt <= '0;
        half     <= !half;
        if (charging_o && (!regul || half)) safety_tick_o <= 1'b1; // R23
      end else begin
        tick_cnt <= tick_cnt + 32'd1;
      end
    end
  end

  // indicator open-drain: low charging, released done, blink fault
  logic [31:0] blink_cnt;
  logic        blink;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt <= '0;
      blink     <= 1'b0;
    end else if (blink_cnt >= 32'(BLINK_DIV - 1)) begin
      blink_cnt <= '0;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'd1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind_o    <= 1'b0;
      ind_oe_o <= 1'b0;
    end else begin
      ind_o <= 1'b0;
      if (ctrl[IND_DIS_B])     ind_oe_o <= 1'b0;  // R20
      else if (st == ST_FAULT) ind_oe_o <= blink; // R20
      else                     ind_oe_o <= (st == ST_PRE) ||
                                           (st == ST_FAST); // R20
    end
  end

  // settings bundle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.eff_input_limit <= next_eff; // R3 R4
      cfg_o.boost_limit_ma  <= boost_ma(boost_current_limit_field); // R5
      cfg_o.boost_voltage   <= boost_voltage_field;
      cfg_o.boost_frequency_select_fast <= ctrl[BST_FRQ_B]; // R7
      cfg_o.min_sys_voltage <= minimum_system_voltage_field; // R10
      cfg_o.charge_voltage  <= vreg;
      cfg_o.fast_current    <= fast_charge_current_field;
      cfg_o.pre_current     <= ipre;
      cfg_o.term_current    <= iterm;
      cfg_o.timer_sel       <= tmr;
      cfg_o.recharge_sel    <= ctrl[RCH_SEL_B]; // R19
      cfg_o.current_sel     <= !s.bat_above_2v ? CUR_SHORT :
                               !s.bat_above_3v ? CUR_PRE : CUR_FAST; // R22
    end
  end

  // read data, zero for unmapped offsets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (rd) begin
      case (adr_i)
        CTRL_OFS:  dat_o <= {23'h0, ctrl};
        EXTERNAL_CURRENT_CLAMP_PIN_OFS:  dat_o <= {18'h0, optimized_input_limit, 2'h0,
                             host_input_current_limit};
        BOOST_OFS: dat_o <= {24'h0, boost_voltage_field, 1'b0,
                             boost_current_limit_field};
        CHG_OFS:   dat_o <= {5'h0, minimum_system_voltage_field, tmr,
                             vreg, iterm, ipre, 1'b0,
                             fast_charge_current_field};
        STAT_OFS:  dat_o <= {16'h0, next_eff, bat_switch_on_o,
                             boost_active_o, idpm_flag, vdpm_flag,
                             sys_flag, charge_phase_field,
                             input_source_status};
        default:   dat_o <= '0;
      endcase
    end
  end

  // checks
  property p_int_pulse;
    @(posedge clk_i) disable iff (rst_i)
      int_o |=> !int_o;
  endproperty
  a_int_pulse: assert property (p_int_pulse) // R24
    else $error("interrupt longer than one cycle");

  property p_int_after_done;
    @(posedge clk_i) disable iff (rst_i)
      int_o |-> charge_phase_field == PH_DONE;
  endproperty
  a_int_after_done: assert property (p_int_after_done) // R21
    else $error("interrupt without done phase");

  property p_boost_src;
    @(posedge clk_i) disable iff (rst_i)
      boost_active_o |=> input_source_status == SRC_BOOST;
  endproperty
  a_boost_src: assert property (p_boost_src) // R8
    else $error("source status not 111 in boost");

  property p_boost_delay;
    @(posedge clk_i) disable iff (rst_i)
      $rose(boost_active_o) |-> $past(bdly_done) && $past(boost_en);
  endproperty
  a_boost_delay: assert property (p_boost_delay) // R6
    else $error("boost started before delay");

  property p_boost_drop;
    @(posedge clk_i) disable iff (rst_i)
      boost_active_o && !s.bat_above_boost |=> !boost_active_o;
  endproperty
  a_boost_drop: assert property (p_boost_drop) // R9
    else $error("boost kept with low battery");

  property p_freq_lock;
    @(posedge clk_i) disable iff (rst_i)
      ctrl[BST_CFG_B] |=> $stable(ctrl[BST_FRQ_B]);
  endproperty
  a_freq_lock: assert property (p_freq_lock) // R7
    else $error("frequency changed while boost configured");

  property p_start_cond;
    @(posedge clk_i) disable iff (rst_i)
      (st == ST_DIS || st == ST_DONE) &&
      (next_st == ST_PRE || next_st == ST_FAST) |->
      s.conv_running && ctrl[CHG_CFG_B] && !s.charge_en_n &&
      fast_charge_current_field != 7'h00 && !s.ts_fault &&
      !s.timer_fault && !ctrl[BSW_DIS_B];
  endproperty
  a_start_cond: assert property (p_start_cond) // R17
    else $error("charge started without conditions");

  property p_no_term_reg;
    @(posedge clk_i) disable iff (rst_i)
      st == ST_FAST && regul |=> st != ST_DONE;
  endproperty
  a_no_term_reg: assert property (p_no_term_reg) // R23
    else $error("terminated during regulation");

  property p_reduce;
    @(posedge clk_i) disable iff (rst_i)
      s.iin_over |=> charge_reduce_o && idpm_flag;
  endproperty
  a_reduce: assert property (p_reduce) // R12
    else $error("overload not reduced");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack timing wrong");
endmodule : cpp_ctrl

`default_nettype wire

// [tb/cpp_opt_model.sv]
// optimizer stand-in that answers run requests with a result
`timescale 1ns/1ps
`default_nettype none
module cpp_opt_model
  import cpp_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // run request and sense pass-through
  input  wire logic       run_i,
  input  wire cpp_sense_t base_i,
  input  wire logic [5:0] val_i,
  output cpp_sense_t      sense_o
);
  logic [2:0] cnt;
  logic [5:0] res;
  // search takes a few cycles, result latched at the run request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 3'h0;
      res <= 6'h08;
    end else if (run_i) begin
      cnt <= 3'h4;
      res <= val_i;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  // done pulse carries the result, the rest passes unchanged
  always_comb begin
    sense_o = base_i;
    sense_o.opt_done = (cnt == 3'h1);
    sense_o.opt_result = res;
  end
endmodule : cpp_opt_model
`default_nettype wire

// [tb/charger_power_path_control_test.sv]
// self-checking bench for the charger power path control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
`define WAITFOR(c) begin for (int k = 0; k < 300 && (c) !== 1'b1; k++) \
  @(posedge clk_i); if ((c) !== 1'b1) begin n_fail++; tally_and_finish(); end end
module charger_power_path_control_test;
  import cpp_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 0;
  logic [3:0]  sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, q;
  logic        ack_o, opt_run_o, boost_active_o, charge_reduce_o;
  logic        bat_switch_on_o, charging_o, int_o, ind_o, ind_oe_o;
  logic        safety_tick_o, b0;
  logic [5:0]  val = 6'h20;
  cpp_sense_t  sn, sense_i;
  cpp_cfg_t    cfg_o;
  int          n_fail = 0, checked = 0, n_int = 0, n_tick = 0, t0;
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (int_o === 1'b1) n_int++;
  always @(posedge clk_i) if (safety_tick_o === 1'b1) n_tick <= n_tick + 1;
  cpp_opt_model u_cpp_opt_model (.clk_i(clk_i), .rst_i(rst_i),
    .run_i(opt_run_o), .base_i(sn), .val_i(val), .sense_o(sense_i));
  cpp_ctrl #(.BOOST_DLY(20), .TICK_DIV(8), .BLINK_DIV(8)) u_cpp_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sense_i(sense_i), .cfg_o(cfg_o),
    .opt_run_o(opt_run_o), .boost_active_o(boost_active_o),
    .charge_reduce_o(charge_reduce_o), .bat_switch_on_o(bat_switch_on_o),
    .charging_o(charging_o), .safety_tick_o(safety_tick_o),
    .int_o(int_o), .ind_o(ind_o), .ind_oe_o(ind_oe_o));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
    sel_i <= 4'hf;
    `WAITFOR(ack_o)
    q = dat_o;
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle
  initial begin
    sn = '0; sn.ext_clamp = 6'h3f; sn.charge_en_n = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    wb(0, CTRL_OFS, 0); `CHK("ctrl", 32'h025, q)
    wb(0, CHG_OFS, 0); `CHK("chg", {5'h0, SMIN_RST, TMR_RST, VREG_RST,
      ITRM_RST, IPRE_RST, 1'b0, FAST_CHARGE_CURRENT_FIELD_RST}, q)
    wb(0, BOOST_OFS, 0); `CHK("bst", {BVOLT_RST, 1'b0, BLIM_RST}, q[7:0])
    wb(0, 8'h20, 0); `CHK("unmapped", 32'h0, q)
    wb(1, BOOST_OFS, 32'h70); settle();
    `CHK("blim", 12'd500, cfg_o.boost_limit_ma)
    // optimizer forced, then clamp, then host limit
    wb(1, CTRL_OFS, 32'h027); `WAITFOR(opt_run_o)
    `CHK("run", 1'b1, opt_run_o)
    settle(); `CHK("lim opt", 6'h20, cfg_o.eff_input_limit)
    sn.ext_clamp <= 6'h10; settle();
    `CHK("lim pin", 6'h10, cfg_o.eff_input_limit)
    wb(1, CTRL_OFS, 32'h021); settle();
    `CHK("lim noclamp", 6'h20, cfg_o.eff_input_limit)
    wb(1, CTRL_OFS, 32'h020); settle();
    `CHK("lim host", HILIM_RST, cfg_o.eff_input_limit)
    // source detection edge runs the optimizer on its own
    wb(1, CTRL_OFS, 32'h021); val <= 6'h18; sn.src_dcp_found <= 1'b1;
    `WAITFOR(opt_run_o) settle(); settle();
    `CHK("lim dcp", 6'h18, cfg_o.eff_input_limit)
    // frequency bit locked while boost configured
    wb(1, CTRL_OFS, 32'h028); wb(1, CTRL_OFS, 32'h038);
    wb(0, CTRL_OFS, 0); `CHK("frq lock", 32'h028, q)
    wb(1, CTRL_OFS, 32'h030); wb(1, CTRL_OFS, 32'h038);
    wb(0, CTRL_OFS, 0); `CHK("frq", 32'h038, q)
    `CHK("frq cfg", 1'b1, cfg_o.boost_frequency_select_fast)
    sn.boost_request_pin <= 1; sn.bat_above_low <= 1; sn.boost_temp_ok <= 1;
    sn.vbus_below_sleep <= 1; sn.bat_above_boost <= 1;
    repeat (10) @(posedge clk_i);
    `CHK("bst early", 1'b0, boost_active_o)
    `WAITFOR(boost_active_o)
    wb(0, STAT_OFS, 0); `CHK("src", SRC_BOOST, q[2:0])
    sn.bat_above_boost <= 0; settle();
    `CHK("bst stop", 1'b0, boost_active_o)
    sn.boost_request_pin <= 0; wb(1, CTRL_OFS, 32'h020);
    // charge cycle: blocked, fast with overload, done
    sn.charge_en_n <= 0; settle();
    `CHK("no conv", 1'b0, charging_o)
    sn.conv_running <= 1; sn.bat_above_2v <= 1; sn.bat_above_3v <= 1;
    sn.iin_over <= 1; sn.ibat_below_term <= 1; sn.bat_above_rechg <= 1;
    `WAITFOR(charging_o) settle();
    wb(0, STAT_OFS, 0); `CHK("ph hold", PH_FAST, q[4:3])
    `CHK("idpm", 1'b1, q[7])
    `CHK("reduce", 1'b1, charge_reduce_o)
    `CHK("cur fast", CUR_FAST, cfg_o.current_sel)
    `CHK("ind chg", 1'b1, ind_oe_o)
    t0 = n_tick; repeat (32) @(posedge clk_i);
    `CHK("tick half", 2, n_tick - t0)
    sn.iin_over <= 0; `WAITFOR(!charging_o) settle();
    wb(0, STAT_OFS, 0); `CHK("ph done", PH_DONE, q[4:3])
    `CHK("ints", 1, n_int)
    `CHK("ind done", 1'b0, ind_oe_o)
    `CHK("ind lvl", 1'b0, ind_o)
    sn.sys_below_bat <= 1; sn.sys_at_min <= 1; settle();
    `CHK("supp", 1'b1, bat_switch_on_o)
    wb(0, STAT_OFS, 0); `CHK("sysmin", 1'b1, q[5])
    sn.bat_depleted <= 1; settle();
    `CHK("depl", 1'b0, bat_switch_on_o)
    // recharge restarts in precharge
    sn.bat_above_rechg <= 0; sn.bat_above_3v <= 0;
    `WAITFOR(charging_o) settle();
    wb(0, STAT_OFS, 0); `CHK("ph pre", PH_PRE, q[4:3])
    `CHK("cur pre", CUR_PRE, cfg_o.current_sel)
    t0 = n_tick; repeat (32) @(posedge clk_i);
    `CHK("tick full", 4, n_tick - t0)
    // fault blinks the indicator, disable bit silences it
    sn.ts_fault <= 1'b1; settle(); b0 = ind_oe_o;
    repeat (8) @(posedge clk_i); `CHK("blink", ~b0, ind_oe_o)
    wb(1, CTRL_OFS, 32'h120); settle();
    `CHK("ind dis", 1'b0, ind_oe_o)
    repeat (8) @(posedge clk_i); `CHK("ind dis2", 1'b0, ind_oe_o)
    // fault clears, cycle completes, enable pin toggle restarts
    sn.ts_fault <= 1'b0; sn.bat_above_3v <= 1; sn.bat_above_rechg <= 1;
    `WAITFOR(int_o) settle(); `CHK("ints2", 2, n_int)
    sn.charge_en_n <= 1; settle(); sn.charge_en_n <= 0;
    `WAITFOR(charging_o) settle(); `CHK("retoggle", 3, n_int)
    sn.vin_under <= 1; settle(); wb(0, STAT_OFS, 0);
    `CHK("vdpm", 1'b1, q[6])
    tally_and_finish();
  end
endmodule : charger_power_path_control_test
`default_nettype wire
